// ---- iepb_chk.sv ----
module iepb_chk
(
   // clock and reset
   input wire logic I_CLK,
   input wire logic I_SYS_RST,
   // apb
   input wire logic I_PSEL,
   input wire logic I_PENABLE,
   input wire logic I_PWRITE,
   input wire logic [11:0] I_PADDR,
   input wire logic [31:0] I_PWDATA,
   input wire logic [3:0] I_PSTRB,
   input wire logic O_PREADY,
   // request side
   input wire logic [14:0] I_IRQ_REQ,
   input wire logic I_IRQ_ACK,
   input wire iepb_pkg::iepb_irq_t O_IRQ
);
   import iepb_pkg::*;
   logic [31:0] sh_q;
   logic [14:0] act_q, pri_q, lvl, low;
   // shadow of the four control bytes
   always_ff @(posedge I_CLK)
   begin
      if (I_SYS_RST)
         sh_q <= '0;
      else if (I_PSEL && I_PENABLE && O_PREADY && I_PWRITE && I_PSTRB[0])
         case (I_PADDR)
            12'h2A0: sh_q[7:0] <= I_PWDATA[7:0];
            12'h2A4: sh_q[15:8] <= I_PWDATA[7:0] & MASK_EN_EXT;
            12'h2E0: sh_q[23:16] <= I_PWDATA[7:0] & MASK_PRI_MAIN;
            12'h2E4: sh_q[31:24] <= I_PWDATA[7:0] & MASK_PRI_EXT;
            default: ;
         endcase
   end
   // eligible sources and levels, one cycle behind like the output
   always_ff @(posedge I_CLK)
   begin
      act_q <= I_IRQ_REQ & {sh_q[15:8], sh_q[6:0]} & {15{sh_q[7]}};
      pri_q <= {sh_q[31:24], sh_q[22:16]};
   end
   // sources of the shown level with a smaller query number
   assign lvl = O_IRQ.high ? pri_q : ~pri_q;
   assign low = (15'h1 << O_IRQ.id) - 15'h1;
   default clocking cb @(posedge I_CLK); endclocking
   default disable iff (I_SYS_RST);
   sequence s_ack_hi;
      I_IRQ_ACK && O_IRQ.valid && O_IRQ.high;
   endsequence
   sequence s_ack_lo;
      I_IRQ_ACK && O_IRQ.valid && !O_IRQ.high;
   endsequence
   property p_rst;
      $fell(I_SYS_RST) |-> O_IRQ == '0 && !O_PREADY;
   endproperty
   a_rst: assert property (p_rst) else $error("not clear after reset");
   property p_gate;
      O_IRQ.valid |-> $past(sh_q[7]);
   endproperty
   a_gate: assert property (p_gate) else $error("request with gate off");
   property p_src;
      O_IRQ.valid |-> act_q[O_IRQ.id];
   endproperty
   a_src: assert property (p_src) else $error("source not allowed");
   property p_lvl;
      O_IRQ.valid |-> O_IRQ.high == pri_q[O_IRQ.id];
   endproperty
   a_lvl: assert property (p_lvl) else $error("wrong level");
   property p_first;
      O_IRQ.valid |-> (act_q & lvl & low) == '0;
   endproperty
   a_first: assert property (p_first) else $error("not smallest");
   property p_pre;
      O_IRQ.valid && !O_IRQ.high |-> (act_q & pri_q) == '0;
   endproperty
   a_pre: assert property (p_pre) else $error("low over high");
   property p_hold_hi;
      s_ack_hi |-> ##2 !O_IRQ.valid;
   endproperty
   a_hold_hi: assert property (p_hold_hi) else $error("shown in high");
   property p_hold_lo;
      s_ack_lo |-> ##2 (!O_IRQ.valid || O_IRQ.high);
   endproperty
   a_hold_lo: assert property (p_hold_lo) else $error("low shown in low");
   property p_rdy;
      I_PSEL && !I_PENABLE |=> O_PREADY ##1 !O_PREADY;
   endproperty
   a_rdy: assert property (p_rdy) else $error("ready not one cycle");
endmodule : iepb_chk

// ---- iepb_core_mdl.sv ----
module iepb_core_mdl
(
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // shown request and bench commands
   input wire iepb_pkg::iepb_irq_t i_irq,
   input wire logic i_arm,
   input wire logic i_ret,
   // handshake
   output logic o_ack,
   output logic o_reti
);
   import iepb_pkg::*;
   logic armed_q;
   // one accept per arming, so a stale request is never taken twice
   always_ff @(posedge i_clk)
   begin
      o_ack <= !i_rst && armed_q && i_irq.valid && !o_ack;
      armed_q <= !i_rst && (i_arm || (armed_q && !(i_irq.valid && !o_ack)));
      o_reti <= !i_rst && i_ret;
   end
endmodule : iepb_core_mdl

// ---- iepb_pkg.sv ----
package iepb_pkg;

   // bus widths
   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;
   localparam int REG_W = 8;
   localparam int SRC_N = 15;
   localparam int ID_W = 4;

   // register indices; byte address is four times the index
   localparam logic [7:0] IDX_EN_MAIN = 8'hA8;
   localparam logic [7:0] IDX_EN_EXT = 8'hA9;
   localparam logic [7:0] IDX_PRI_MAIN = 8'hB8;
   localparam logic [7:0] IDX_PRI_EXT = 8'hB9;
   localparam logic [7:0] IDX_STATUS = 8'hC0;

   // writable bit masks, reserved positions are zero
   localparam logic [7:0] MASK_EN_MAIN = 8'hFF;
   localparam logic [7:0] MASK_EN_EXT = 8'hDF;
   localparam logic [7:0] MASK_PRI_MAIN = 8'h7F;
   localparam logic [7:0] MASK_PRI_EXT = 8'hDF;
   localparam logic [7:0] RST_REG = 8'h00;

   // main enable / priority bit positions
   localparam int B_EXT0 = 0;
   localparam int B_TMR0 = 1;
   localparam int B_EXT1 = 2;
   localparam int B_TMR1 = 3;
   localparam int B_SERIAL = 4;
   localparam int B_TMR2 = 5;
   localparam int B_ADC = 6;
   localparam int B_GATE = 7;

   // extended enable / priority bit positions
   localparam int B_COMBO0 = 0;
   localparam int B_PWM = 1;
   localparam int B_BASE = 2;
   localparam int B_EXT2 = 3;
   localparam int B_TOUCH = 4;
   localparam int B_TMR3 = 6;
   localparam int B_TMR4 = 7;

   // query numbers, smaller is served first among requests of equal level
   localparam int Q_EXT0 = 0;
   localparam int Q_TMR0 = 1;
   localparam int Q_EXT1 = 2;
   localparam int Q_TMR1 = 3;
   localparam int Q_SERIAL = 4;
   localparam int Q_TMR2 = 5;
   localparam int Q_ADC = 6;
   localparam int Q_COMBO0 = 7;
   localparam int Q_PWM = 8;
   localparam int Q_BASE = 9;
   localparam int Q_EXT2 = 10;
   localparam int Q_TOUCH = 11;
   localparam int Q_UNUSED = 12;
   localparam int Q_TMR3 = 13;
   localparam int Q_TMR4 = 14;

   // status register bit positions
   localparam int S_LOW_ACT = 0;
   localparam int S_HIGH_ACT = 1;
   localparam int S_VALID = 2;
   localparam int S_LEVEL = 3;
   localparam int S_ID_LSB = 4;

   // request presented to the core
   typedef struct packed {
      logic valid;
      logic high;
      logic [ID_W-1:0] id;
   } iepb_irq_t;

endpackage : iepb_pkg

// ---- iepb_tb_top.sv ----
module iepb_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import iepb_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic psel = 1'b0;
   logic pen = 1'b0;
   logic pwr = 1'b0;
   logic arm = 1'b0;
   logic ret = 1'b0;
   logic [11:0] padr = '0;
   logic [31:0] pwd = '0;
   logic [14:0] req = '0;
   logic [3:0] pstrb = 4'hF;
   logic [31:0] prd;
   logic rdy, err, ack, reti;
   iepb_irq_t irq;
   int mismatches = 0;
   int num_checks = 0;
   int cyc = 0;
   logic [11:0] adr [4] = '{12'h2A0, 12'h2A4, 12'h2E0, 12'h2E4};
   logic [7:0] msk [4] = '{MASK_EN_MAIN, MASK_EN_EXT, MASK_PRI_MAIN, MASK_PRI_EXT};
   iepb_top iepb_top_i
   (
      .I_CLK(clk), .I_SYS_RST(rst), .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr),
      .I_PADDR(padr), .I_PWDATA(pwd), .I_PSTRB(pstrb), .O_PRDATA(prd), .O_PREADY(rdy),
      .O_PSLVERR(err), .I_IRQ_REQ(req), .I_IRQ_ACK(ack), .I_IRQ_RETI(reti), .O_IRQ(irq)
   );
   iepb_core_mdl iepb_core_mdl_i
   (
      .i_clk(clk), .i_rst(rst), .i_irq(irq), .i_arm(arm), .i_ret(ret), .o_ack(ack),
      .o_reti(reti)
   );
   always #50 clk = ~clk;
   // cut a hang short
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 4000)
      begin
         mismatches++;
         wrap_up();
      end
   end
   task automatic wrap_up();
      if (mismatches == 0 && num_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : wrap_up
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e)
      begin
         mismatches++;
         $display("FAIL %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   // one apb transfer, held until ready is seen at an edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] rd, output logic er);
      psel <= 1'b1;
      pwr <= w;
      padr <= a;
      pwd <= d;
      @(posedge clk);
      pen <= 1'b1;
      do
         @(posedge clk);
      while (rdy !== 1'b1);
      rd = prd;
      er = err;
      psel <= 1'b0;
      pen <= 1'b0;
      @(posedge clk);
   endtask : apb
   task automatic cfg(input logic [7:0] em, ee, pm, pe);
      logic [31:0] rd;
      logic er;
      apb(1'b1, adr[0], {24'h0, em}, rd, er);
      apb(1'b1, adr[1], {24'h0, ee}, rd, er);
      apb(1'b1, adr[2], {24'h0, pm}, rd, er);
      apb(1'b1, adr[3], {24'h0, pe}, rd, er);
   endtask : cfg
   task automatic probe(input logic [14:0] r, input logic [5:0] e);
      req <= r;
      repeat (3) @(posedge clk);
      chk("irq", {26'h0, e}, {26'h0, irq});
      req <= '0;
      repeat (2) @(posedge clk);
   endtask : probe
   // arm the core for one accept, or pulse a return
   task automatic core(input logic r);
      arm <= !r;
      ret <= r;
      @(posedge clk);
      arm <= 1'b0;
      ret <= 1'b0;
      repeat (4) @(posedge clk);
   endtask : core
   initial
   begin
      logic [31:0] rd;
      logic er;
      logic [7:0] m, e;
      logic [14:0] r;
      logic [3:0] id;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      // reset values, then writable bits after writing all ones
      for (int i = 0; i < 4; i++)
      begin
         apb(1'b0, adr[i], '0, rd, er);
         chk("reset value", 32'h0, rd);
         chk("mapped no error", 32'h0, {31'h0, er});
         apb(1'b1, adr[i], 32'hFFFF_FFFF, rd, er);
         apb(1'b0, adr[i], '0, rd, er);
         chk("writable bits", {24'h0, msk[i]}, rd);
      end
      apb(1'b0, 12'h004, '0, rd, er);
      chk("unmapped error", 32'h1, {31'h0, er});
      // a write with lane 0 strobe off leaves the register alone
      pstrb <= 4'hE;
      apb(1'b1, adr[0], '0, rd, er);
      pstrb <= 4'hF;
      apb(1'b0, adr[0], '0, rd, er);
      chk("strobe off", {24'h0, msk[0]}, rd);
      // each source alone: allowed, high level, gate off, masked
      for (int q = 0; q < 15; q++)
      begin
         if (q == 12)
            continue;
         m = q < 7 ? 8'h1 << q : 8'h0;
         e = q < 7 ? 8'h0 : 8'h1 << (q - 7);
         r = 15'h1 << q;
         id = 4'(q);
         cfg(8'h80 | m, e, 8'h0, 8'h0);
         probe(r, {2'b10, id});
         cfg(8'h80 | m, e, m, e);
         probe(r, {2'b11, id});
         cfg(m, e, m, e);
         probe(r, 6'h0);
         cfg(~m, ~e, 8'h0, 8'h0);
         probe(r, 6'h0);
      end
      // several at once
      cfg(8'hFF, 8'hFF, 8'h0, 8'h0);
      probe(15'h6000, 6'h2D);
      probe(15'h7FFE, 6'h21);
      probe(15'h1000, 6'h0);
      cfg(8'hFF, 8'hFF, 8'h0, 8'h80);
      probe(15'h7FFF, 6'h3E);
      // nesting: low served, high preempts, equal level waits for return
      cfg(8'hFF, 8'hFF, 8'h0, 8'h02);
      req <= 15'h0008;
      core(1'b0);
      chk("low held", 32'h0, {26'h0, irq});
      req <= 15'h0108;
      repeat (3) @(posedge clk);
      chk("preempt", 32'h38, {26'h0, irq});
      // status: low in service, high id 8 shown
      apb(1'b0, 12'h300, '0, rd, er);
      chk("status", 32'h0000_008D, rd);
      core(1'b0);
      chk("high held", 32'h0, {26'h0, irq});
      req <= 15'h0008;
      core(1'b1);
      chk("low still held", 32'h0, {26'h0, irq});
      core(1'b1);
      chk("after return", 32'h23, {26'h0, irq});
      wrap_up();
   end
endmodule : iepb_tb_top
bind iepb_top iepb_chk iepb_chk_i
(
   .I_CLK, .I_SYS_RST, .I_PSEL, .I_PENABLE, .I_PWRITE, .I_PADDR, .I_PWDATA,
   .I_PSTRB, .O_PREADY, .I_IRQ_REQ, .I_IRQ_ACK, .O_IRQ
);

// ---- iepb_top.sv ----
// Contract
// - bit 7 of main enable is global gate; clear blocks every request
// - main enable bit 6 allows the converter-done request
// - main enable bits 1, 3, 5 allow timer 0, 1, 2 overflow
// - main enable bits 0 and 2 allow external lines 0 and 1
// - main enable bit 4 allows the serial request
// - extended enable bits 6 and 7 allow timer 3 and timer 4
// - extended enable bit 4 allows the touch counter request
// - extended enable bit 3 allows external line 2
// - extended enable bit 2 allows the base tick request
// - extended enable bit 1 allows the pwm period overflow request
// - extended enable bit 0 allows the combined serial unit 0 request
// - main priority bit 6 sets converter request level, 1 is high
// - main priority bits 1, 3, 5 set timer 0, 1, 2 levels
// - main priority bits 0 and 2 set external lines 0, 1 levels
// - main priority bit 4 sets serial request level
// - extended priority bits 6, 7 set timer 3, 4 levels
// - extended priority bit 4 sets touch counter level
// - extended priority bit 3 sets external line 2 level
// - extended priority bit 2 sets base tick level
// - extended priority bit 1 sets pwm overflow level
// - extended priority bit 0 sets combined serial unit 0 level
// - high preempts running low; same or lower waits until return
// - among equal level requests smallest query number goes first
module iepb_top
(
   // clock and reset
   input wire logic I_CLK,
   input wire logic I_SYS_RST,
   // apb slave
   input wire logic I_PSEL,
   input wire logic I_PENABLE,
   input wire logic I_PWRITE,
   input wire logic [iepb_pkg::ADDR_W-1:0] I_PADDR,
   input wire logic [iepb_pkg::DATA_W-1:0] I_PWDATA,
   input wire logic [3:0] I_PSTRB,
   output logic [iepb_pkg::DATA_W-1:0] O_PRDATA,
   output logic O_PREADY,
   output logic O_PSLVERR,
   // request sources, indexed by query number
   input wire logic [iepb_pkg::SRC_N-1:0] I_IRQ_REQ,
   // processor core
   input wire logic I_IRQ_ACK,
   input wire logic I_IRQ_RETI,
   output iepb_pkg::iepb_irq_t O_IRQ
);
   import iepb_pkg::*;

   // byte address of a register index
   function automatic logic [ADDR_W-1:0] reg_addr(input logic [7:0] idx);
      reg_addr = {2'b00, idx, 2'b00};
   endfunction : reg_addr

   // spread main/extended register bits onto query number order
   function automatic logic [SRC_N-1:0] by_query(input logic [REG_W-1:0] m,
                                                 input logic [REG_W-1:0] e);
      logic [SRC_N-1:0] v;
      v = '0;
      v[Q_EXT0] = m[B_EXT0];
      v[Q_TMR0] = m[B_TMR0];
      v[Q_EXT1] = m[B_EXT1];
      v[Q_TMR1] = m[B_TMR1];
      v[Q_SERIAL] = m[B_SERIAL];
      v[Q_TMR2] = m[B_TMR2];
      v[Q_ADC] = m[B_ADC];
      v[Q_COMBO0] = e[B_COMBO0];
      v[Q_PWM] = e[B_PWM];
      v[Q_BASE] = e[B_BASE];
      v[Q_EXT2] = e[B_EXT2];
      v[Q_TOUCH] = e[B_TOUCH];
      v[Q_UNUSED] = 1'b0;
      v[Q_TMR3] = e[B_TMR3];
      v[Q_TMR4] = e[B_TMR4];
      by_query = v;
   endfunction : by_query

   // lowest set query number of a request vector
   function automatic logic [ID_W-1:0] first_set(input logic [SRC_N-1:0] v);
      logic [ID_W-1:0] r;
      r = '0;
      for (int i = SRC_N - 1; i >= 0; i--)
      begin
         if (v[i])
         begin
            r = ID_W'(i);
         end
      end
      first_set = r;
   endfunction : first_set

   // control registers
   logic [REG_W-1:0] en_main_q;
   logic [REG_W-1:0] en_ext_q;
   logic [REG_W-1:0] pri_main_q;
   logic [REG_W-1:0] pri_ext_q;

   // in-service state
   logic low_act_q;
   logic high_act_q;

   // bus outputs
   logic [DATA_W-1:0] prdata_q;
   logic pready_q;
   logic pslverr_q;
   iepb_irq_t irq_q;
   iepb_irq_t irq_d;

   // decode
   logic setup;
   logic access;
   logic wr_en;
   logic hit_en_main;
   logic hit_en_ext;
   logic hit_pri_main;
   logic hit_pri_ext;
   logic hit_status;
   logic hit_any;
   logic [REG_W-1:0] wbyte;
   logic [REG_W-1:0] rd_byte;
   logic [REG_W-1:0] status;

   // arbitration
   logic [SRC_N-1:0] allow;
   logic [SRC_N-1:0] level;
   logic [SRC_N-1:0] pend;
   logic [SRC_N-1:0] pend_high;
   logic [SRC_N-1:0] pend_low;

   // apb phase and address decode
   assign setup = I_PSEL & ~I_PENABLE;
   assign access = I_PSEL & I_PENABLE & pready_q;
   assign hit_en_main = (I_PADDR == reg_addr(IDX_EN_MAIN));
   assign hit_en_ext = (I_PADDR == reg_addr(IDX_EN_EXT));
   assign hit_pri_main = (I_PADDR == reg_addr(IDX_PRI_MAIN));
   assign hit_pri_ext = (I_PADDR == reg_addr(IDX_PRI_EXT));
   assign hit_status = (I_PADDR == reg_addr(IDX_STATUS));
   assign hit_any = hit_en_main | hit_en_ext | hit_pri_main | hit_pri_ext | hit_status;
   assign wr_en = access & I_PWRITE & I_PSTRB[0] & ~pslverr_q;
   assign wbyte = I_PWDATA[REG_W-1:0];

   // state visible to software
   always_comb
   begin
      status = '0;
      status[S_LOW_ACT] = low_act_q;
      status[S_HIGH_ACT] = high_act_q;
      status[S_VALID] = irq_q.valid;
      status[S_LEVEL] = irq_q.high;
      status[S_ID_LSB +: ID_W] = irq_q.id;
   end

   // read mux
   always_comb
   begin
      rd_byte = '0;
      if (hit_en_main)
      begin
         rd_byte = en_main_q;
      end
      else if (hit_en_ext)
      begin
         rd_byte = en_ext_q;
      end
      else if (hit_pri_main)
      begin
         rd_byte = pri_main_q;
      end
      else if (hit_pri_ext)
      begin
         rd_byte = pri_ext_q;
      end
      else if (hit_status)
      begin
         rd_byte = status;
      end
   end

   // answer is prepared in setup, shown in the one access cycle
   always_ff @(posedge I_CLK)
   begin
      if (I_SYS_RST)
      begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h0000_0000;
      end
      else
      begin
         pready_q <= setup;
         pslverr_q <= setup & ~hit_any;
         if (setup & ~I_PWRITE)
         begin
            prdata_q <= {{(DATA_W-REG_W){1'b0}}, rd_byte};
         end
      end
   end

   // enable registers
   always_ff @(posedge I_CLK)
   begin
      if (I_SYS_RST)
      begin
         en_main_q <= RST_REG;
         en_ext_q <= RST_REG;
      end
      else
      begin
         if (wr_en & hit_en_main)
         begin
            en_main_q <= wbyte & MASK_EN_MAIN;
         end
         if (wr_en & hit_en_ext)
         begin
            en_ext_q <= wbyte & MASK_EN_EXT;
         end
      end
   end

   // priority registers
   always_ff @(posedge I_CLK)
   begin
      if (I_SYS_RST)
      begin
         pri_main_q <= RST_REG;
         pri_ext_q <= RST_REG;
      end
      else
      begin
         if (wr_en & hit_pri_main)
         begin
            pri_main_q <= wbyte & MASK_PRI_MAIN;
         end
         if (wr_en & hit_pri_ext)
         begin
            pri_ext_q <= wbyte & MASK_PRI_EXT;
         end
      end
   end

   // per-source allow bits in query order
   // main and extended allow bits
   assign allow = by_query(en_main_q, en_ext_q);

   // per-source level bits in query order
   // main and extended level bits
   assign level = by_query(pri_main_q, pri_ext_q);

   assign pend = I_IRQ_REQ & allow & {SRC_N{en_main_q[B_GATE]}};
   assign pend_high = pend & level;
   assign pend_low = pend & ~level;

   // choose what to present to the core
   always_comb
   begin
      irq_d = '0;
      // high only when no high running
      if ((|pend_high) & ~high_act_q)
      begin
         irq_d.valid = 1'b1;
         irq_d.high = 1'b1;
         irq_d.id = first_set(pend_high);
      end
      // low waits for any running routine
      else if ((|pend_low) & ~high_act_q & ~low_act_q)
      begin
         irq_d.valid = 1'b1;
         irq_d.high = 1'b0;
         irq_d.id = first_set(pend_low);
      end
   end

   // registered request towards the core
   always_ff @(posedge I_CLK)
   begin
      if (I_SYS_RST)
      begin
         irq_q <= '0;
      end
      else
      begin
         irq_q <= irq_d;
      end
   end

   // in-service levels: set on accept, return clears the top one
   always_ff @(posedge I_CLK)
   begin
      if (I_SYS_RST)
      begin
         low_act_q <= 1'b0;
         high_act_q <= 1'b0;
      end
      else
      begin
         // nesting tracked per level, accept wins over return
         if (I_IRQ_ACK & irq_q.valid & irq_q.high)
         begin
            high_act_q <= 1'b1;
         end
         else if (I_IRQ_RETI & high_act_q)
         begin
            high_act_q <= 1'b0;
         end
         if (I_IRQ_ACK & irq_q.valid & ~irq_q.high)
         begin
            low_act_q <= 1'b1;
         end
         else if (I_IRQ_RETI & ~high_act_q)
         begin
            low_act_q <= 1'b0;
         end
      end
   end

   // outputs straight from flops
   assign O_PRDATA = prdata_q;
   assign O_PREADY = pready_q;
   assign O_PSLVERR = pslverr_q;
   assign O_IRQ = irq_q;

endmodule : iepb_top
